// File: pkg/hcw_pkg.sv
package hcw_pkg;

  // ----------------------------------------------------------------
  // Addresses and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] HCW_CFG_ADDR      = 8'h7E; // Indirect index of the word
  localparam logic [7:0] HCW_RESET_VALUE   = 8'hFF; // Unprogrammed state
  localparam logic [7:0] HCW_RDATA_RESET   = 8'h00; // Readback while reset is held
  localparam logic [7:0] HCW_UNMAP_VALUE   = 8'h00; // Other indices read as zero
  localparam int         HCW_DBL_MSB       = 7;
  localparam int         HCW_DBL_LSB       = 6;
  localparam int         HCW_ABL_MSB       = 5;
  localparam int         HCW_ABL_LSB       = 4;
  localparam int         HCW_ABRO_BIT      = 3;
  localparam int         HCW_DBRO_BIT      = 2;
  localparam int         HCW_P0_BIT        = 1;
  localparam int         HCW_P23_BIT       = 0;

  // Brownout trip level codes
  typedef enum logic [1:0] {
    HCW_LVL_4V5 = 2'h0,
    HCW_LVL_4V2 = 2'h1,
    HCW_LVL_2V7 = 2'h2,
    HCW_LVL_2V5 = 2'h3
  } hcw_level_t;

  // Operating modes of the device
  typedef enum logic [1:0] {
    HCW_MODE_USER     = 2'h0,
    HCW_MODE_SER_PROG = 2'h1,
    HCW_MODE_PAR_PROG = 2'h3
  } hcw_mode_t;

  // Decoded controls
  typedef struct packed {
    hcw_level_t digital_brownout_level;
    hcw_level_t analog_brownout_level;
    logic       analog_brownout_reset_en;
    logic       digital_brownout_reset_en;
    logic       port0_ext_bus;
    logic       port2_ext_bus;
    logic       p3_strobes_en;
  } hcw_ctrl_t;

  // Controls while reset is held: erased levels, resets and buses off
  localparam hcw_ctrl_t HCW_CTRL_RESET = '{
    digital_brownout_level:    HCW_LVL_2V5,
    analog_brownout_level:     HCW_LVL_2V5,
    analog_brownout_reset_en:  1'b0,
    digital_brownout_reset_en: 1'b0,
    port0_ext_bus:             1'b0,
    port2_ext_bus:             1'b0,
    p3_strobes_en:             1'b0
  };

  // Loader states
  typedef enum logic [1:0] {
    HCW_ST_LOAD = 2'h0,
    HCW_ST_RUN  = 2'h1
  } hcw_state_t;

endpackage : hcw_pkg

// File: verilog/hcw_config_word.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Digital brownout level codes 0..3 pick 4.5, 4.2, 2.7, 2.5 V, and 3 is the erased default.
// - Analog brownout level codes 0..3 pick 4.5, 4.2, 2.7, 2.5 V, and 3 is the erased default.
// - Analog brownout reset is applied only when its disable bit is 0, default off.
// - Digital brownout reset is applied only when its disable bit is 0, default off.
// - Port-0 select 0 gives port 0 to the external bus with P3.6/P3.7 as strobes, 1 is GPIO.
// - Ports-2/3 select 0 gives port 2 to the external bus with P3.6/P3.7 as strobes, 1 is GPIO.
// - The word at index 7Eh is written only in programming mode and is readable in user mode.
// - Configuration changes outside serial or parallel programming mode are ignored.
module hcw_config_word (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire hcw_pkg::hcw_mode_t mode,
  input  wire logic [7:0]         config_index_reg,
  input  wire logic [7:0]         config_value_wdata,
  input  wire logic               config_value_wr,
  output logic [7:0]              config_value_rdata,
  output logic [7:0]              stored_word,
  output hcw_pkg::hcw_ctrl_t      ctrl,
  output logic                    loaded
);
  import hcw_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  // Non-volatile cell model, kept across reset
  logic [7:0] store_reg;
  logic [7:0] store_next;

  // Readback of the indirect data register
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Word captured at the last reset release
  logic [7:0] live_reg;
  logic [7:0] live_next;

  // Decoded controls held until the next reset
  hcw_ctrl_t  ctrl_reg;
  hcw_ctrl_t  ctrl_next;

  // Loader sequence and its done flag
  hcw_state_t state_reg;
  hcw_state_t state_next;
  logic       loaded_reg;
  logic       loaded_next;

  // Qualifiers of the indirect access
  logic       prog_mode;
  logic       index_hit;
  logic       write_ok;

  // Fields of the cell, split out for decode
  hcw_level_t dbl_field;
  hcw_level_t abl_field;
  logic       abro_off;
  logic       dbro_off;
  logic       p0_gpio;
  logic       p23_gpio;
  hcw_ctrl_t  decoded;

  // ----------------------------------------------------------------
  // Access qualifiers
  // ----------------------------------------------------------------

  // Writes only in serial or parallel programming
  assign prog_mode = (mode == HCW_MODE_SER_PROG) || (mode == HCW_MODE_PAR_PROG);

  // Only one index maps to this word
  assign index_hit = (config_index_reg == HCW_CFG_ADDR);

  // Write strobe qualified by index and mode
  assign write_ok  = config_value_wr && prog_mode && index_hit;

  // ----------------------------------------------------------------
  // Cell model
  // ----------------------------------------------------------------

  // Next cell content: a qualified write replaces the byte
  always_comb begin
    store_next = store_reg;
    if (write_ok) begin
      store_next = config_value_wdata;
    end
  end

  // No reset here, or a reset would erase the stored word
  always_ff @(posedge clk) begin
    store_reg <= store_next;
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------

  // Word readable in any mode, other indices read as zero
  always_comb begin
    rdata_next = HCW_UNMAP_VALUE;
    if (index_hit) begin
      rdata_next = store_reg;
    end
  end

  // One cycle from index to data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= HCW_RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------

  // Digital trip level from its two-bit code
  always_comb begin
    case (hcw_level_t'(store_reg[HCW_DBL_MSB:HCW_DBL_LSB]))
      HCW_LVL_4V5: begin
        dbl_field = HCW_LVL_4V5;
      end
      HCW_LVL_4V2: begin
        dbl_field = HCW_LVL_4V2;
      end
      HCW_LVL_2V7: begin
        dbl_field = HCW_LVL_2V7;
      end
      default: begin
        dbl_field = HCW_LVL_2V5;
      end
    endcase
  end

  // Analog trip level from its two-bit code
  always_comb begin
    case (hcw_level_t'(store_reg[HCW_ABL_MSB:HCW_ABL_LSB]))
      HCW_LVL_4V5: begin
        abl_field = HCW_LVL_4V5;
      end
      HCW_LVL_4V2: begin
        abl_field = HCW_LVL_4V2;
      end
      HCW_LVL_2V7: begin
        abl_field = HCW_LVL_2V7;
      end
      default: begin
        abl_field = HCW_LVL_2V5;
      end
    endcase
  end

  // Single-bit disable and select fields
  always_comb begin
    abro_off = store_reg[HCW_ABRO_BIT];
    dbro_off = store_reg[HCW_DBRO_BIT];
    p0_gpio  = store_reg[HCW_P0_BIT];
    p23_gpio = store_reg[HCW_P23_BIT];
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Active-high enables are the inverse of the stored bits, the strobe enable is the OR of both inverted port selects
  always_comb begin
    decoded.digital_brownout_level    = dbl_field;
    decoded.analog_brownout_level     = abl_field;
    decoded.analog_brownout_reset_en  = ~abro_off;
    decoded.digital_brownout_reset_en = ~dbro_off;
    decoded.port0_ext_bus             = ~p0_gpio;
    decoded.port2_ext_bus             = ~p23_gpio;
    decoded.p3_strobes_en             = ~p0_gpio | ~p23_gpio;
  end

  // ----------------------------------------------------------------
  // Loader
  // ----------------------------------------------------------------

  // First edge after reset release captures word and controls
  always_comb begin
    state_next  = state_reg;
    loaded_next = loaded_reg;
    live_next   = live_reg;
    ctrl_next   = ctrl_reg;
    case (state_reg)
      HCW_ST_LOAD: begin
        live_next   = store_reg;
        ctrl_next   = decoded;
        loaded_next = 1'b1;
        state_next  = HCW_ST_RUN;
      end
      HCW_ST_RUN: begin
        state_next = HCW_ST_RUN;
      end
      default: begin
        state_next  = HCW_ST_LOAD;
        loaded_next = 1'b0;
      end
    endcase
  end

  // Async reset parks the loader and shows erased controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= HCW_ST_LOAD;
      loaded_reg <= 1'b0;
      live_reg   <= HCW_RESET_VALUE;
      ctrl_reg   <= HCW_CTRL_RESET;
    end else begin
      state_reg  <= state_next;
      loaded_reg <= loaded_next;
      live_reg   <= live_next;
      ctrl_reg   <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output comes from a flip-flop
  assign config_value_rdata = rdata_reg;
  assign stored_word        = live_reg;
  assign ctrl               = ctrl_reg;
  assign loaded             = loaded_reg;

endmodule : hcw_config_word

// File: verification/hcw_sva.sv
`timescale 1ns/1ps
module hcw_sva (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire hcw_pkg::hcw_mode_t mode,
  input wire logic [7:0]         config_index_reg,
  input wire logic [7:0]         config_value_wdata,
  input wire logic               config_value_wr,
  input wire logic [7:0]         config_value_rdata,
  input wire logic [7:0]         stored_word,
  input wire hcw_pkg::hcw_ctrl_t ctrl,
  input wire logic               loaded
);
  import hcw_pkg::*;
  // Decode, access and hold checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_dbl_decode: assert property (ctrl.digital_brownout_level == stored_word[7:6]) else $error("dbl");
  a_abl_decode: assert property (ctrl.analog_brownout_level == stored_word[5:4]) else $error("abl");
  a_bo_reset_en: assert property ({ctrl.analog_brownout_reset_en, ctrl.digital_brownout_reset_en}
    == ~stored_word[3:2]) else $error("enable");
  a_port_select: assert property ({ctrl.port0_ext_bus, ctrl.port2_ext_bus, ctrl.p3_strobes_en}
    == {~stored_word[1:0], ~&stored_word[1:0]}) else $error("port");
  a_write_taken: assert property ((config_value_wr && config_index_reg == HCW_CFG_ADDR && mode[0])
    ##1 (config_index_reg == HCW_CFG_ADDR && !config_value_wr)
    |=> config_value_rdata == $past(config_value_wdata, 2)) else $error("write");
  a_unmapped_read: assert property (config_index_reg != HCW_CFG_ADDR |=> config_value_rdata == 8'h00)
    else $error("unmapped");
  a_user_locked: assert property ((config_index_reg == HCW_CFG_ADDR && mode == HCW_MODE_USER)[*3]
    |-> $stable(config_value_rdata)) else $error("locked");
  a_word_hold: assert property (loaded |=> $stable(stored_word) && $stable(ctrl)) else $error("hold");
endmodule : hcw_sva
bind hcw_config_word hcw_sva i_hcw_sva (
  .clk                (clk),
  .rst_n              (rst_n),
  .mode               (mode),
  .config_index_reg   (config_index_reg),
  .config_value_wdata (config_value_wdata),
  .config_value_wr    (config_value_wr),
  .config_value_rdata (config_value_rdata),
  .stored_word        (stored_word),
  .ctrl               (ctrl),
  .loaded             (loaded)
);

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hcw_pkg::*;
  logic       clk = 0, rst_n = 0, wr = 0, loaded;
  logic [7:0] idx = 8'h7E, wd = 0, rd, sw, v;
  hcw_mode_t  mode = HCW_MODE_USER;
  hcw_ctrl_t  ctrl;
  int         mismatches = 0, cmp_count = 0;
  initial forever #2.5 clk = ~clk;
  hcw_config_word i_hcw_config_word (.clk, .rst_n, .mode, .config_index_reg(idx), .config_value_wdata(wd),
    .config_value_wr(wr), .config_value_rdata(rd), .stored_word(sw), .ctrl, .loaded);
  task automatic chk(logic [8:0] s, logic [8:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // One write pulse, then back to idle user reads
  task automatic put(hcw_mode_t m, logic [7:0] a, logic [7:0] d);
    mode = m;
    idx = a;
    wd = d;
    wr = 1;
    step(1);
    wr = 0;
    mode = HCW_MODE_USER;
    idx = 8'h7E;
    step(1);
  endtask : put
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
  // Program, refuse, reload per pattern
  initial begin
    step(18);
    put(HCW_MODE_SER_PROG, 8'h7E, 8'hFF); // Erase the cell before the first load
    chk(loaded, 0);
    chk(sw, 8'hFF);
    chk(rd, 0);
    rst_n = 1;
    step(1);
    chk(loaded, 1);
    chk(sw, 8'hFF);
    put(HCW_MODE_SER_PROG, 8'h7E, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      v = 8'(i * 8'h55);
      put(i[0] ? HCW_MODE_PAR_PROG : HCW_MODE_SER_PROG, 8'h7E, v);
      chk(rd, v);
      put(HCW_MODE_USER, 8'h7E, ~v);
      put(hcw_mode_t'(2'h2), 8'h7E, ~v);
      chk(rd, v);
      put(HCW_MODE_SER_PROG, 8'h7D, ~v);
      chk(rd, v);
      rst_n = 0;
      step(2);
      rst_n = 1;
      step(1);
      chk(sw, v);
      chk(ctrl, {v[7:4], ~v[3:0], ~&v[1:0]});
      idx = 8'h7D;
      step(2);
      chk(rd, 0);
    end
    end_of_test();
  end
endmodule : tb_top
